// file: core/cpu_reset_sequencer.sv
// Reset sequencer that steers the clock, loads the vector and initialises core state
`timescale 1ns/10ps
module cpu_reset_sequencer
#(
	parameter int unsigned MIN_LOW = reset_seq_pkg::MIN_RESET_CYCLES
)
(
	// Clock and power-up reset
	input wire logic clock,
	input wire logic reset,
	// External reset pin
	input wire logic reset_pin_n,
	// Boot width straps
	input wire logic boot_width_pin_low,
	input wire logic boot_width_pin_high,
	// Vector memory read port
	output logic [23:0] vector_addr,
	output logic vector_read,
	input wire logic [7:0] vector_data,
	input wire logic vector_valid,
	// Clock controller
	output logic pll_bypass,
	output logic [2:0] clock_gear,
	// Core state
	output logic [23:0] program_counter,
	output logic [31:0] stack_pointer_reg,
	output logic [2:0] interrupt_mask_level,
	output logic [1:0] register_bank_select,
	output logic core_run,
	// Peripherals and ports
	output logic peripheral_reset,
	output logic port_general_purpose,
	output logic bus_width_8bit,
	output logic boot_mode_reserved
);
	reset_seq_pkg::seq_state_t state;
	reset_seq_pkg::seq_state_t next_state;
	logic accepted;
	logic released;
	logic pc_ready;

	initial
	begin
		if (MIN_LOW < 1)
			$error("MIN_LOW must be at least one");
	end

	reset_filter #(.COUNT(MIN_LOW)) filter
	(
		.clock(clock),
		.reset(reset),
		.reset_pin_n(reset_pin_n),
		.accepted(accepted),
		.released(released)
	);

	// Sequencer
	always_comb
	begin
		next_state = state;
		case (state)
			reset_seq_pkg::st_run:
				if (accepted)
					next_state = reset_seq_pkg::st_hold;
			reset_seq_pkg::st_hold:
				next_state = reset_seq_pkg::st_fetch_low;
			reset_seq_pkg::st_fetch_low:
				if (vector_valid)
					next_state = reset_seq_pkg::st_fetch_mid;
			reset_seq_pkg::st_fetch_mid:
				if (vector_valid)
					next_state = reset_seq_pkg::st_fetch_high;
			reset_seq_pkg::st_fetch_high:
				if (vector_valid)
					next_state = reset_seq_pkg::st_wait_release;
			reset_seq_pkg::st_wait_release:
				if (released)
					next_state = reset_seq_pkg::st_run;
			default:
				next_state = reset_seq_pkg::st_hold;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			state <= reset_seq_pkg::st_hold;
		else
			state <= next_state;
	end

	// Vector fetch addressing
	always_comb
	begin
		vector_read = 1'b0;
		vector_addr = reset_seq_pkg::VECTOR_ADDR_LOW;
		if (state == reset_seq_pkg::st_fetch_low)
			vector_read = 1'b1;
		else if (state == reset_seq_pkg::st_fetch_mid)
		begin
			vector_read = 1'b1;
			vector_addr = reset_seq_pkg::VECTOR_ADDR_MID;
		end
		else if (state == reset_seq_pkg::st_fetch_high)
		begin
			vector_read = 1'b1;
			vector_addr = reset_seq_pkg::VECTOR_ADDR_HIGH;
		end
	end

	// Program counter from vector bytes
	always_ff @(posedge clock)
	begin
		if (reset)
			program_counter <= 24'h000000;
		else if (vector_valid && state == reset_seq_pkg::st_fetch_low)
			program_counter[7:0] <= vector_data;
		else if (vector_valid && state == reset_seq_pkg::st_fetch_mid)
			program_counter[15:8] <= vector_data;
		else if (vector_valid && state == reset_seq_pkg::st_fetch_high)
			program_counter[23:16] <= vector_data;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			pc_ready <= 1'b0;
		else if (state == reset_seq_pkg::st_hold)
			pc_ready <= 1'b0;
		else if (vector_valid && state == reset_seq_pkg::st_fetch_high)
			pc_ready <= 1'b1;
	end

	// Named core registers; everything else in the core is untouched
	always_ff @(posedge clock)
	begin
		if (reset || state == reset_seq_pkg::st_hold)
		begin
			stack_pointer_reg <= reset_seq_pkg::STACK_RESET;
			interrupt_mask_level <= reset_seq_pkg::MASK_RESET;
			register_bank_select <= reset_seq_pkg::BANK_RESET;
		end
	end

	// Strap capture each cycle in st_wait_release, after the vector fetch
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			bus_width_8bit <= 1'b0;
			boot_mode_reserved <= 1'b0;
		end
		else if (state == reset_seq_pkg::st_wait_release)
		begin
			bus_width_8bit <= ({boot_width_pin_high, boot_width_pin_low} == reset_seq_pkg::BOOT_8BIT);
			boot_mode_reserved <= ({boot_width_pin_high, boot_width_pin_low} != reset_seq_pkg::BOOT_8BIT) &&
				({boot_width_pin_high, boot_width_pin_low} != reset_seq_pkg::BOOT_16BIT);
		end
	end

	// Reset-wide outputs
	assign core_run = (state == reset_seq_pkg::st_run) && pc_ready;
	assign peripheral_reset = (state != reset_seq_pkg::st_run);
	assign port_general_purpose = peripheral_reset;
	assign pll_bypass = peripheral_reset ? reset_seq_pkg::BYPASS_PLL : 1'b0;
	assign clock_gear = peripheral_reset ? reset_seq_pkg::GEAR_DIV16 : 3'h0;

	gear_in_reset_a: assert property (@(posedge clock) disable iff (reset)
		peripheral_reset |-> (clock_gear == 3'h4 && pll_bypass))
		else $error("clock not slowed during reset");
	fetch_order_a: assert property (@(posedge clock) disable iff (reset)
		(vector_read && vector_valid && vector_addr == 24'hFFFF00) |=> vector_addr == 24'hFFFF01)
		else $error("vector fetch out of order");
	pc_high_a: assert property (@(posedge clock) disable iff (reset)
		(state == reset_seq_pkg::st_fetch_high && vector_valid) |=> program_counter[23:16] == $past(vector_data))
		else $error("program counter high byte wrong");
	stack_clear_a: assert property (@(posedge clock) disable iff (reset)
		state == reset_seq_pkg::st_hold |=> stack_pointer_reg == 32'h0)
		else $error("stack pointer not cleared");
	mask_level_a: assert property (@(posedge clock) disable iff (reset)
		state == reset_seq_pkg::st_hold |=> interrupt_mask_level == 3'h7)
		else $error("mask level not seven");
	bank_select_a: assert property (@(posedge clock) disable iff (reset)
		state == reset_seq_pkg::st_hold |=> register_bank_select == 2'h0)
		else $error("bank not zero");
	run_after_load_a: assert property (@(posedge clock) disable iff (reset)
		core_run |-> pc_ready && !peripheral_reset && $stable(program_counter))
		else $error("core ran before vector load");
	regs_hold_a: assert property (@(posedge clock) disable iff (reset)
		(state == reset_seq_pkg::st_run && $past(state) == reset_seq_pkg::st_run)
		|-> $stable(stack_pointer_reg) && $stable(register_bank_select) && $stable(interrupt_mask_level))
		else $error("core register changed outside reset");
	ports_gp_a: assert property (@(posedge clock) disable iff (reset)
		peripheral_reset |-> port_general_purpose)
		else $error("ports not general purpose in reset");
	prompt_release_a: assert property (@(posedge clock) disable iff (reset)
		(state == reset_seq_pkg::st_wait_release && released) |=> !peripheral_reset)
		else $error("internal reset stretched");
endmodule

// file: core/reset_seq_pkg.sv
// Constants and types for the core reset sequencer
// Behaviour
// - During reset the multiplier is bypassed and the clock gear is one sixteenth.
// - Program counter loads from three vector bytes, low byte at lowest address.
// - Stack pointer clears to zero when reset is accepted.
// - Interrupt mask level is set to 111 on reset.
// - Register bank select clears to 00 on reset.
// - After release the core fetches from the loaded program counter.
// - Core registers not named keep their previous value across reset.
// - Peripheral control registers take their reset values.
// - All port pins return to general-purpose mode on reset.
// - Internal reset ends one cycle after the synchronised external reset is seen high.
package reset_seq_pkg;
	localparam int unsigned MIN_RESET_CYCLES = 20;
	localparam logic [23:0] VECTOR_ADDR_LOW = 24'hFFFF00;
	localparam logic [23:0] VECTOR_ADDR_MID = 24'hFFFF01;
	localparam logic [23:0] VECTOR_ADDR_HIGH = 24'hFFFF02;
	localparam logic [31:0] STACK_RESET = 32'h00000000;
	localparam logic [2:0] MASK_RESET = 3'h7;
	localparam logic [1:0] BANK_RESET = 2'h0;
	localparam logic [2:0] GEAR_DIV16 = 3'h4;
	localparam logic BYPASS_PLL = 1'b1;
	localparam logic [1:0] BOOT_16BIT = 2'h1;
	localparam logic [1:0] BOOT_8BIT = 2'h2;

	typedef enum logic [2:0]
	{
		st_run = 3'h0,
		st_hold = 3'h1,
		st_fetch_low = 3'h2,
		st_fetch_mid = 3'h3,
		st_fetch_high = 3'h4,
		st_wait_release = 3'h5
	} seq_state_t;
endpackage

// file: core/reset_filter.sv
// Low-sample counter that qualifies the external reset input
`timescale 1ns/10ps
module reset_filter
#(
	parameter int unsigned COUNT = reset_seq_pkg::MIN_RESET_CYCLES
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Pin
	input wire logic reset_pin_n,
	// Result
	output logic accepted,
	output logic released
);
	localparam int unsigned W = $clog2(COUNT + 1);
	logic [W-1:0] low_count;
	logic sync_a;
	logic sync_b;

	initial
	begin
		if (COUNT < 1)
			$error("reset_filter COUNT must be at least one");
	end

	// Two-stage synchroniser
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
		end
		else
		begin
			sync_a <= reset_pin_n;
			sync_b <= sync_a;
		end
	end

	// Consecutive low samples
	always_ff @(posedge clock)
	begin
		if (reset)
			low_count <= '0;
		else if (sync_b)
			low_count <= '0;
		else if (low_count != W'(COUNT))
			low_count <= low_count + W'(1);
	end

	assign accepted = (low_count == W'(COUNT));
	assign released = sync_b;

	count_cap_a: assert property (@(posedge clock) disable iff (reset) low_count <= W'(COUNT))
		else $error("low count exceeded its cap");
	glitch_reject_a: assert property (@(posedge clock) disable iff (reset)
		$rose(accepted) |-> $past(!sync_b, COUNT > 8 ? 8 : COUNT))
		else $error("reset accepted without enough low samples");
endmodule

// file: dv/reset_source.sv
// Reset source and vector memory model facing the sequencer
`timescale 1ns/10ps
module reset_source
(
	// Clock and memory side
	input wire logic clock,
	input wire logic [23:0] vector_addr,
	input wire logic vector_read,
	input wire logic [23:0] vec,
	input wire logic [1:0] delay,
	// Driven lines
	output logic reset_pin_n,
	output logic [7:0] vector_data,
	output logic vector_valid
);
	int cnt = 0;
	initial
	begin
		reset_pin_n = 1'b1;
		vector_data = 8'hA5;
		vector_valid = 1'b0;
	end
	// Pin low for n clocks, then back to its pull-up level
	task hold_low(input int n);
		@(negedge clock);
		reset_pin_n <= 1'b0;
		repeat (n) @(negedge clock);
		reset_pin_n <= 1'b1;
	endtask
	// One byte per valid cycle, held back to back when delay is zero
	always @(negedge clock)
	begin
		if (vector_read && (vector_valid ? delay == 2'h0 : cnt >= delay))
		begin
			vector_valid <= 1'b1;
			vector_data <= vec[{vector_addr[1:0], 3'h0} +: 8];
			cnt <= 0;
		end
		else
		begin
			vector_valid <= 1'b0;
			vector_data <= ~vector_data;
			cnt <= (vector_read && !vector_valid) ? cnt + 1 : 0;
		end
	end
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/10ps
module tb_top;
	localparam int unsigned LOW = 3;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic boot_width_pin_low = 1'b0;
	logic boot_width_pin_high = 1'b0;
	logic [23:0] vec = 24'h5AC3E1;
	logic [1:0] delay = 2'h1;
	logic reset_pin_n, vector_read, vector_valid, pll_bypass, core_run, peripheral_reset;
	logic port_general_purpose, bus_width_8bit, boot_mode_reserved;
	logic [23:0] vector_addr, program_counter;
	logic [7:0] vector_data;
	logic [2:0] clock_gear, interrupt_mask_level;
	logic [31:0] stack_pointer_reg;
	logic [1:0] register_bank_select;
	integer seed = 32'h2B4E;
	int error_cnt = 0;
	int checks = 0;
	initial
	begin
		forever #5 clock = ~clock;
	end
	cpu_reset_sequencer #(.MIN_LOW(LOW)) uut (.clock, .reset, .reset_pin_n, .boot_width_pin_low,
		.boot_width_pin_high, .vector_addr, .vector_read, .vector_data, .vector_valid, .pll_bypass,
		.clock_gear, .program_counter, .stack_pointer_reg, .interrupt_mask_level, .register_bank_select,
		.core_run, .peripheral_reset, .port_general_purpose, .bus_width_8bit, .boot_mode_reserved);
	reset_source src (.clock, .vector_addr, .vector_read, .vec, .delay, .reset_pin_n, .vector_data,
		.vector_valid);
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task give_verdict;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Strap decode: {8-bit start, reserved}
	function logic [1:0] exp_mode(input logic lo, input logic hi);
		return {hi & ~lo, hi == lo};
	endfunction
	task wait_run(output int n);
		n = 0;
		while (core_run !== 1'b1)
		begin
			@(posedge clock);
			#1;
			n++;
			if (n > 200)
			begin
				error_cnt++;
				give_verdict;
			end
		end
	endtask
	task verify_run(input logic lo, input logic hi);
		check("pc", program_counter, vec);
		check("sp", stack_pointer_reg, reset_seq_pkg::STACK_RESET);
		check("mask", interrupt_mask_level, reset_seq_pkg::MASK_RESET);
		check("bank", register_bank_select, reset_seq_pkg::BANK_RESET);
		check("run", core_run, 1'b1);
		check("periph", peripheral_reset, 1'b0);
		check("ports", port_general_purpose, 1'b0);
		check("gear", {pll_bypass, clock_gear}, 4'h0);
		check("mode", {bus_width_8bit, boot_mode_reserved}, exp_mode(lo, hi));
	endtask
	task pin_reset(input logic lo, input logic hi);
		int n;
		@(negedge clock);
		boot_width_pin_low <= lo;
		boot_width_pin_high <= hi;
		vec <= 24'($random(seed));
		delay <= 2'($random(seed));
		fork
			src.hold_low(LOW + 16 + int'($unsigned($random(seed)) % 8));
			begin
				n = 0;
				while (peripheral_reset !== 1'b1 && n < 40)
				begin
					@(posedge clock);
					#1;
					n++;
				end
				check("enter", n < LOW + 6, 1'b1);
				check("bypass", pll_bypass, reset_seq_pkg::BYPASS_PLL);
				check("div16", clock_gear, reset_seq_pkg::GEAR_DIV16);
				check("ports", port_general_purpose, 1'b1);
				check("halt", core_run, 1'b0);
			end
		join
		wait_run(n);
		check("release", n <= 5, 1'b1);
		verify_run(lo, hi);
		$display("pin reset test done");
	endtask
	initial
	begin
		int n;
		repeat (2) @(negedge clock);
		reset <= 1'b0;
		wait_run(n);
		verify_run(1'b0, 1'b0);
		$display("power-up test done");
		src.hold_low(LOW - 1);
		repeat (8) @(negedge clock);
		check("glitch run", core_run, 1'b1);
		check("glitch periph", peripheral_reset, 1'b0);
		$display("glitch test done");
		for (int i = 0; i < 8; i++)
			pin_reset(i[0], i[1]);
		give_verdict;
	end
endmodule
